// *** sim/ccw_asserts.sv ***
// ccw_asserts: port checks for the comparator control block
// assumes one mclk domain, bound to every instance of the block
`timescale 1ns/1ns
module ccw_asserts
   import ccw_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst_b,
   // register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // power and core control
   input wire logic        sleep_req,
   input wire logic        cmp_enable,
   input wire logic        cmp_low_power,
   input wire logic        cmp_sig_on_neg,
   input wire logic        cmp_ref_internal,
   input wire logic [1:0]  cmp_hyst,
   input wire logic        pins_owned,
   // interrupts
   input wire logic        sysctrl_irq,
   input wire logic        analog_irq,
   input wire logic        wake_req
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // sleep goes through two flops, so four quiet samples rule out a late one
   sequence s_awake;
      !sleep_req [*4];
   endsequence
   sequence s_ctl(logic en);
      reg_wr && reg_addr == CCW_CTRL_OFS && reg_wdata[0] && cmp_enable == en;
   endsequence
   a_analog_quiet: assert property (!analog_irq)
      else $error("analogue line raised");
   a_pins_follow: assert property (pins_owned == cmp_enable)
      else $error("pins not tied to run");
   a_start_std: assert property (s_awake ##0 s_ctl(1'h0) |=> cmp_enable && !cmp_low_power
      && cmp_hyst == $past(reg_wdata[4:3]) && cmp_sig_on_neg == $past(reg_wdata[1])
      && cmp_ref_internal == $past(reg_wdata[2]))
      else $error("enable did not apply settings");
   a_lp_switch: assert property (s_awake ##0 s_ctl(1'h1) |=> cmp_low_power == $past(reg_wdata[5]))
      else $error("power mode not switched");
   a_stop_now: assert property (reg_wr && reg_addr == CCW_CTRL_OFS && !reg_wdata[0]
      |=> !cmp_enable)
      else $error("disable late");
   a_sleep_lp: assert property (sleep_req [*4] |-> cmp_low_power && !cmp_ref_internal)
      else $error("sleep mode not forced");
   a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_int_off: assert property (reg_wr && reg_addr == CCW_INTCFG_OFS && !reg_wdata[0]
      |=> !sysctrl_irq && !wake_req)
      else $error("irq after disable");
   a_irq_holds: assert property (sysctrl_irq && !reg_wr |=> sysctrl_irq)
      else $error("irq dropped uncleared");
endmodule : ccw_asserts

bind ccw_comparator_control_wake ccw_asserts i_chk (
   .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req), .cmp_enable(cmp_enable),
   .cmp_low_power(cmp_low_power), .cmp_sig_on_neg(cmp_sig_on_neg),
   .cmp_ref_internal(cmp_ref_internal), .cmp_hyst(cmp_hyst), .pins_owned(pins_owned),
   .sysctrl_irq(sysctrl_irq), .analog_irq(analog_irq), .wake_req(wake_req));

// *** sim/ccw_pin_model.sv ***
// ccw_pin_model: comparator core and its two pins, levels in mV
// assumes the bench sets pin levels; runs on mclk
`timescale 1ns/1ns
module ccw_pin_model (
   // clock
   input  wire logic               mclk,
   // core control
   input  wire logic               cmp_enable,
   input  wire logic               cmp_low_power,
   input  wire logic               cmp_sig_on_neg,
   input  wire logic               cmp_ref_internal,
   input  wire logic [1:0]         cmp_hyst,
   // levels
   input  wire logic signed [31:0] pos_mv,
   input  wire logic signed [31:0] neg_mv,
   input  wire logic signed [31:0] vref_mv,
   // raw level
   output logic                    ana_out
);
   int   sig, thr, hy;
   int   cnt = 0;
   logic lvl = 1'h0;
   logic out_r = 1'h0;
   assign ana_out = out_r;
   always_comb begin
      sig = cmp_sig_on_neg ? neg_mv : pos_mv;
      thr = cmp_ref_internal ? vref_mv : (cmp_sig_on_neg ? pos_mv : neg_mv);
      hy = (cmp_hyst == 2'h3) ? 20 : 5 * int'(cmp_hyst);
   end
   always @(posedge mclk) begin
      if (sig > thr + hy) lvl <= 1'h1;
      else if (sig < thr - hy) lvl <= 1'h0;
      if (!cmp_enable) begin
         // stopped core toggles its output every cycle, so never a stale level
         out_r <= ~out_r;
         cnt <= 0;
      end else if (out_r != lvl && cnt < (cmp_low_power ? 6 : 2)) cnt <= cnt + 1;
      else begin
         out_r <= lvl;
         cnt <= 0;
      end
   end
endmodule : ccw_pin_model

// *** sim/tb_top.sv ***
// tb_top: self-checking bench for the comparator control block
// assumes the pin model on the analogue side, mclk at 20 MHz
`timescale 1ns/1ns
module tb_top
   import ccw_pkg::*;
;
   logic        mclk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, sleep_req = 1'h0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_q;
   logic [1:0]  cmp_hyst;
   logic        ana_out, cmp_enable, cmp_low_power, cmp_sig_on_neg, cmp_ref_internal;
   logic        pins_owned, sysctrl_irq, analog_irq, wake_req;
   // pins stay plain inputs and no converter runs here
   int          pos_mv = 0, neg_mv = 1000, vref_mv = 1000, fails = 0, checked = 0;

   initial forever #25 mclk = ~mclk;

   ccw_comparator_control_wake #(.STD_SETTLE(4), .LP_SETTLE(8)) i_dut (
      .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
      .ana_out(ana_out), .cmp_enable(cmp_enable), .cmp_low_power(cmp_low_power),
      .cmp_sig_on_neg(cmp_sig_on_neg), .cmp_ref_internal(cmp_ref_internal),
      .cmp_hyst(cmp_hyst), .pins_owned(pins_owned), .sysctrl_irq(sysctrl_irq),
      .analog_irq(analog_irq), .wake_req(wake_req));
   ccw_pin_model i_pins (
      .mclk(mclk), .cmp_enable(cmp_enable), .cmp_low_power(cmp_low_power),
      .cmp_sig_on_neg(cmp_sig_on_neg), .cmp_ref_internal(cmp_ref_internal),
      .cmp_hyst(cmp_hyst), .pos_mv(pos_mv), .neg_mv(neg_mv), .vref_mv(vref_mv),
      .ana_out(ana_out));

   task automatic stop_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      @(negedge mclk);
      rd_q = reg_rdata;
   endtask : rd
   // polls the output level; a level that never comes ends the run
   task automatic wait_out(input logic e);
      for (int n = 0; n < 60; n++) begin
         rd(CCW_STATUS_OFS);
         if (rd_q[CCW_ST_OUT_BIT] === e) break;
      end
      chk(32'(rd_q[CCW_ST_OUT_BIT]), 32'(e));
      if (rd_q[CCW_ST_OUT_BIT] !== e) stop_test();
   endtask : wait_out
   task automatic step(input int mv, input logic e, input logic [31:0] st);
      pos_mv <= mv;
      wait_out(e);
      rd(CCW_IRQ_ST_OFS);
      chk(rd_q, st);
   endtask : step

   task automatic t_regs();
      for (int i = 0; i < 8; i++) begin
         rd(8'(i * 4));
         chk(rd_q, 32'h0);
      end
      chk(32'({pins_owned, analog_irq, sysctrl_irq}), 32'h0);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_compare();
      wr(CCW_CTRL_OFS, 32'h19);
      @(negedge mclk);
      chk(32'({cmp_enable, pins_owned, cmp_low_power, cmp_hyst}), 32'h1B);
      pos_mv <= 1015;
      repeat (20) @(posedge mclk);
      wait_out(1'h0);
      pos_mv <= 1025;
      wait_out(1'h1);
      pos_mv <= 985;
      repeat (20) @(posedge mclk);
      wait_out(1'h1);
      pos_mv <= 975;
      wait_out(1'h0);
      $display("t_compare done");
   endtask : t_compare
   task automatic t_source();
      wr(CCW_CTRL_OFS, 32'h0);
      @(negedge mclk);
      chk(32'({cmp_enable, pins_owned}), 32'h0);
      neg_mv <= 1100;
      wr(CCW_CTRL_OFS, 32'h07);
      @(negedge mclk);
      chk(32'({cmp_sig_on_neg, cmp_ref_internal, cmp_hyst}), 32'hC);
      wait_out(1'h1);
      vref_mv <= 1200;
      wait_out(1'h0);
      $display("t_source done");
   endtask : t_source
   task automatic t_irq();
      wr(CCW_CTRL_OFS, 32'h0);
      vref_mv <= 1000;
      neg_mv <= 1000;
      pos_mv <= 900;
      wr(CCW_CTRL_OFS, 32'h01);
      wr(CCW_IRQ_MSK_OFS, 32'h3);
      wr(CCW_INTCFG_OFS, 32'h3);
      wait_out(1'h0);
      step(1100, 1'h1, 32'h1);
      chk(32'({sysctrl_irq, analog_irq}), 32'h2);
      wr(CCW_IRQ_MSK_OFS, 32'h0);
      @(negedge mclk);
      chk(32'(sysctrl_irq), 32'h0);
      wr(CCW_IRQ_MSK_OFS, 32'h3);
      wr(CCW_IRQ_ST_OFS, 32'h1);
      @(negedge mclk);
      chk(32'(sysctrl_irq), 32'h0);
      step(900, 1'h0, 32'h0);
      wr(CCW_INTCFG_OFS, 32'h1);
      step(1100, 1'h1, 32'h0);
      step(900, 1'h0, 32'h1);
      wr(CCW_INTCFG_OFS, 32'h0);
      @(negedge mclk);
      chk(32'(sysctrl_irq), 32'h0);
      wr(CCW_IRQ_ST_OFS, 32'h3);
      $display("t_irq done");
   endtask : t_irq
   task automatic t_sleep();
      wr(CCW_INTCFG_OFS, 32'h3);
      wr(CCW_CTRL_OFS, 32'h21);
      @(negedge mclk);
      chk(32'(cmp_low_power), 32'h1);
      wr(CCW_CTRL_OFS, 32'h0);
      wr(CCW_CTRL_OFS, 32'h05);
      @(negedge mclk);
      chk(32'({cmp_low_power, cmp_ref_internal}), 32'h1);
      wait_out(1'h0);
      @(posedge mclk);
      sleep_req <= 1'h1;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk(32'({cmp_low_power, cmp_ref_internal}), 32'h2);
      pos_mv <= 1100;
      for (int n = 0; n < 300 && wake_req !== 1'h1; n++) @(negedge mclk);
      chk(32'({wake_req, sysctrl_irq}), 32'h3);
      if (wake_req !== 1'h1) stop_test();
      @(posedge mclk);
      sleep_req <= 1'h0;
      rd(CCW_WAKE_OFS);
      chk(rd_q, 32'h1);
      wr(CCW_WAKE_OFS, 32'h1);
      wr(CCW_IRQ_ST_OFS, 32'h3);
      @(negedge mclk);
      chk(32'(wake_req), 32'h0);
      $display("t_sleep done");
   endtask : t_sleep

   initial begin
      repeat (12) @(posedge mclk);
      rst_b <= 1'h1;
      t_regs();
      t_compare();
      t_source();
      t_irq();
      t_sleep();
      stop_test();
   end
endmodule : tb_top

// *** src/ccw_comparator_control_wake.sv ***
// ccw_comparator_control_wake: control, status and events of one threshold comparator
// assumes an analogue comparator macro driven by the cmp_* outputs and
// returning its raw level asynchronously on ana_out
`timescale 1ns/1ns
module ccw_comparator_control_wake
   import ccw_pkg::*;
#(
   parameter int STD_SETTLE = CCW_STD_SETTLE_CYC,
   parameter int LP_SETTLE  = CCW_LP_SETTLE_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // power state from system controller
   input  wire logic        sleep_req,
   // analogue macro
   input  wire logic        ana_out,
   output logic             cmp_enable,
   output logic             cmp_low_power,
   output logic             cmp_sig_on_neg,
   output logic             cmp_ref_internal,
   output logic [1:0]       cmp_hyst,
   // pin ownership
   output logic             pins_owned,
   // interrupts
   output logic             sysctrl_irq,
   output logic             analog_irq,
   output logic             wake_req
);
   initial begin
      if (STD_SETTLE < 1 || LP_SETTLE < STD_SETTLE || LP_SETTLE > 4095)
         $error("ccw: settle counts out of range");
   end

   // register state
   logic                run_q;
   logic                sig_neg_q;
   logic                ref_int_q;
   logic [1:0]          hyst_q;
   logic                lp_q;
   logic                int_en_q;
   logic                int_rise_q;
   logic [CCW_EV_W-1:0] ev_st_q;
   logic [CCW_EV_W-1:0] ev_msk_q;
   logic                out_q;
   logic                out_prev_q;
   logic [31:0]         rdata_q;
   logic                sleep_q;

   // decoded strobes
   logic wr_ctrl;
   logic wr_int;
   logic wr_irq_st;
   logic wr_msk;
   logic wr_wake;

   assign wr_ctrl   = reg_wr && (reg_addr == CCW_CTRL_OFS);
   assign wr_int    = reg_wr && (reg_addr == CCW_INTCFG_OFS);
   assign wr_irq_st = reg_wr && (reg_addr == CCW_IRQ_ST_OFS);
   assign wr_msk    = reg_wr && (reg_addr == CCW_IRQ_MSK_OFS);
   assign wr_wake   = reg_wr && (reg_addr == CCW_WAKE_OFS);

   // synchronised analogue output and sleep level
   logic ana_s;
   logic sleep_s;

   ccw_sync u_sync_out (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (ana_out),
      .q     (ana_s)
   );

   ccw_sync u_sync_sleep (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (sleep_req),
      .q     (sleep_s)
   );

   // control register; config is only taken on the enable write that starts a stopped core
   logic en_bit;
   logic en_rise;
   assign en_bit  = reg_wdata[CCW_CTRL_EN_BIT];
   assign en_rise = wr_ctrl && en_bit && !run_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         run_q     <= CCW_CTRL_RST[CCW_CTRL_EN_BIT];
         sig_neg_q <= CCW_CTRL_RST[CCW_CTRL_SIG_BIT];
         ref_int_q <= CCW_CTRL_RST[CCW_CTRL_REF_BIT];
         hyst_q    <= CCW_CTRL_RST[CCW_CTRL_HYS_LSB +: 2];
      end else if (wr_ctrl) begin
         run_q <= en_bit;
         if (en_rise) begin
            sig_neg_q <= reg_wdata[CCW_CTRL_SIG_BIT];
            ref_int_q <= reg_wdata[CCW_CTRL_REF_BIT];
            hyst_q    <= reg_wdata[CCW_CTRL_HYS_LSB +: 2];
         end
      end
   end

   // power mode: enable starts in standard power, own bit changes it later
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         lp_q <= CCW_CTRL_RST[CCW_CTRL_LP_BIT];
      else if (en_rise)
         lp_q <= 1'b0;
      else if (wr_ctrl)
         lp_q <= reg_wdata[CCW_CTRL_LP_BIT];
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         sleep_q <= 1'b0;
      else
         sleep_q <= sleep_s;
   end

   // interrupt config: enable and polarity in one write
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         int_en_q   <= CCW_INT_RST[CCW_INT_EN_BIT];
         int_rise_q <= CCW_INT_RST[CCW_INT_RISE_BIT];
      end else if (wr_int) begin
         int_en_q   <= reg_wdata[CCW_INT_EN_BIT];
         int_rise_q <= reg_wdata[CCW_INT_RISE_BIT];
      end
   end

   // analogue macro controls
   logic lp_eff;
   assign lp_eff           = lp_q || sleep_s;
   assign cmp_enable       = run_q;
   assign cmp_low_power    = lp_eff;
   assign cmp_sig_on_neg   = sig_neg_q;
   assign cmp_ref_internal = ref_int_q && !sleep_s;
   assign cmp_hyst         = hyst_q;
   assign pins_owned       = run_q;

   // settling: raw output is untrusted after start, mode or config change
   logic        settle_start;
   logic        settling;
   logic [11:0] settle_cyc;
   assign settle_start = en_rise || (wr_ctrl && run_q) || (sleep_s != sleep_q);
   assign settle_cyc   = lp_eff ? 12'(LP_SETTLE) : 12'(STD_SETTLE);

   ccw_settle #(
      .CNT_W (12)
   ) u_settle (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .start  (settle_start),
      .cycles (settle_cyc),
      .busy   (settling)
   );

   // reported output; hysteresis lives in the macro thresholds
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         out_q <= 1'b0;
      else if (!run_q)
         out_q <= 1'b0;
      else if (!settling)
         out_q <= ana_s;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         out_prev_q <= 1'b0;
      else
         out_prev_q <= out_q;
   end

   // edge qualification: only the configured polarity counts
   // out_q is frozen while settling, so no settle gate here; one would drop
   // an edge whose compare cycle meets a settle restart
   logic edge_hit;
   assign edge_hit = run_q && int_en_q &&
                     (int_rise_q ? (out_q && !out_prev_q)
                                 : (!out_q && out_prev_q));

   // sticky events; set beats a write-one clear in the same cycle
   logic [CCW_EV_W-1:0] ev_set;
   logic [CCW_EV_W-1:0] ev_clr;
   always_comb begin
      ev_set = '0;
      ev_set[CCW_EV_EDGE_BIT] = edge_hit;
      ev_set[CCW_EV_WAKE_BIT] = edge_hit && sleep_s;
      ev_clr = '0;
      if (wr_irq_st)
         ev_clr = reg_wdata[CCW_EV_W-1:0];
      if (wr_wake)
         ev_clr[CCW_EV_WAKE_BIT] = reg_wdata[0];
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         ev_st_q <= '0;
      else
         ev_st_q <= (ev_st_q & ~ev_clr) | ev_set;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         ev_msk_q <= CCW_MSK_RST;
      else if (wr_msk)
         ev_msk_q <= reg_wdata[CCW_EV_W-1:0];
   end

   // system request held while flag, mask and enable stand together; wake request needs only flag and enable
   assign sysctrl_irq = int_en_q && |(ev_st_q & ev_msk_q);
   assign analog_irq  = 1'b0;
   assign wake_req    = int_en_q && ev_st_q[CCW_EV_WAKE_BIT];

   // read path, one cycle later; reads never touch state
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         rdata_q <= 32'h0000_0000;
      else if (reg_rd) begin
         rdata_q <= 32'h0000_0000;
         unique case (reg_addr)
            CCW_CTRL_OFS: begin
               rdata_q[CCW_CTRL_EN_BIT]          <= run_q;
               rdata_q[CCW_CTRL_SIG_BIT]         <= sig_neg_q;
               rdata_q[CCW_CTRL_REF_BIT]         <= ref_int_q;
               rdata_q[CCW_CTRL_HYS_LSB +: 2]    <= hyst_q;
               rdata_q[CCW_CTRL_LP_BIT]          <= lp_q;
            end
            CCW_INTCFG_OFS: begin
               rdata_q[CCW_INT_EN_BIT]   <= int_en_q;
               rdata_q[CCW_INT_RISE_BIT] <= int_rise_q;
            end
            CCW_STATUS_OFS: begin
               rdata_q[CCW_ST_OUT_BIT] <= out_q;
               rdata_q[CCW_ST_RUN_BIT] <= run_q;
               rdata_q[CCW_ST_LP_BIT]  <= lp_eff;
            end
            CCW_IRQ_ST_OFS:  rdata_q[CCW_EV_W-1:0] <= ev_st_q;
            CCW_IRQ_MSK_OFS: rdata_q[CCW_EV_W-1:0] <= ev_msk_q;
            CCW_WAKE_OFS:    rdata_q[0] <= ev_st_q[CCW_EV_WAKE_BIT];
            default:         rdata_q <= 32'h0000_0000;
         endcase
      end else
         rdata_q <= 32'h0000_0000;
   end

   assign reg_rdata = rdata_q;
endmodule : ccw_comparator_control_wake

// *** src/ccw_pkg.sv ***
// ccw_pkg: register map, field layout and timing for comparator control
// assumes a plain strobe register port on mclk at 20 MHz
package ccw_pkg;
   // register offsets (byte addresses, one word each)
   localparam logic [7:0] CCW_CTRL_OFS    = 8'h00;
   localparam logic [7:0] CCW_INTCFG_OFS  = 8'h04;
   localparam logic [7:0] CCW_STATUS_OFS  = 8'h08;
   localparam logic [7:0] CCW_IRQ_ST_OFS  = 8'h0C;
   localparam logic [7:0] CCW_IRQ_MSK_OFS = 8'h10;
   localparam logic [7:0] CCW_WAKE_OFS    = 8'h14;

   // control register fields
   localparam int CCW_CTRL_EN_BIT   = 0;
   localparam int CCW_CTRL_SIG_BIT  = 1;
   localparam int CCW_CTRL_REF_BIT  = 2;
   localparam int CCW_CTRL_HYS_LSB  = 3;
   localparam int CCW_CTRL_LP_BIT   = 5;
   // interrupt config fields
   localparam int CCW_INT_EN_BIT    = 0;
   localparam int CCW_INT_RISE_BIT  = 1;
   // status fields
   localparam int CCW_ST_OUT_BIT    = 0;
   localparam int CCW_ST_RUN_BIT    = 1;
   localparam int CCW_ST_LP_BIT     = 2;
   // event bits in status/mask
   localparam int CCW_EV_EDGE_BIT   = 0;
   localparam int CCW_EV_WAKE_BIT   = 1;
   localparam int CCW_EV_W          = 2;

   localparam logic [31:0] CCW_CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] CCW_INT_RST   = 32'h0000_0000;
   localparam logic [CCW_EV_W-1:0] CCW_MSK_RST = 2'h0;

   // hysteresis codes
   typedef enum logic [1:0] {
      CCW_HYS_0MV  = 2'h0,
      CCW_HYS_5MV  = 2'h1,
      CCW_HYS_10MV = 2'h2,
      CCW_HYS_20MV = 2'h3
   } ccw_hys_t;

   // settling windows for the analogue output, in ns
   localparam int CCW_STD_SETTLE_NS = 1000;
   localparam int CCW_LP_SETTLE_NS  = 10000;
   localparam int CCW_CLK_NS        = 50;
   localparam int CCW_STD_SETTLE_CYC = (CCW_STD_SETTLE_NS + CCW_CLK_NS - 1) / CCW_CLK_NS;
   localparam int CCW_LP_SETTLE_CYC  = (CCW_LP_SETTLE_NS + CCW_CLK_NS - 1) / CCW_CLK_NS;
endpackage : ccw_pkg

// *** src/ccw_settle.sv ***
// ccw_settle: masks the analogue output while it settles after a change
// assumes start pulses on the same clock
`timescale 1ns/1ns
module ccw_settle #(
   parameter int CNT_W = 12
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_b,
   // control
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] cycles,
   output logic                  busy
);
   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         cnt_q <= '0;
      else if (start)
         cnt_q <= cycles;
      else if (cnt_q != '0)
         cnt_q <= cnt_q - 1'b1;
   end

   assign busy = (cnt_q != '0);
endmodule : ccw_settle

// *** src/ccw_sync.sv ***
// ccw_sync: two-flop synchroniser for one asynchronous level
// assumes d is asynchronous to mclk
`timescale 1ns/1ns
module ccw_sync (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // level
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : ccw_sync
